// ### verif/spwm_stage_mdl.sv
`default_nettype none
// Power stage load: tallies high cycles per pin over a window the bench opens
module spwm_stage_mdl (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       reset_n,
   // Window start from the bench
   input  wire logic       clr,
   // Pins from the generator
   input  wire logic [5:0] pwm_out,
   // High-time tallies
   output var  int         hi_cnt [6]
);
   timeunit 1ns;
   timeprecision 1ns;
   // Tally per pin; a clear beats counting so the window is exact
   always @(posedge clock or negedge reset_n) begin
      for (int i = 0; i < 6; i++) begin
         if (!reset_n || clr) begin
            hi_cnt[i] <= 0;
         end else begin
            hi_cnt[i] <= hi_cnt[i] + int'(pwm_out[i]);
         end
      end
   end
endmodule
`default_nettype wire

// ### verif/spwm_top_chk.sv
`include "spwm_map.svh"
`default_nettype none
module spwm_top_chk
   import spwm_pkg::*;
(
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       reset_n,
   // Register port
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_write,
   input  wire logic       reg_read,
   input  wire logic [7:0] reg_rdata,
   // Power stage pins
   input  wire logic [5:0] pwm_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // Shadow copies of the settings that shape the pins
   logic [5:0] men_r, men_nxt;   // Mask enables
   logic [5:0] lvl_r, lvl_nxt;   // Mask levels
   logic [5:0] pol_r, pol_nxt;   // Pin inversion
   logic [1:0] mode_r, mode_nxt; // Output mode
   logic       run_r, run_nxt;   // Counter running
   logic [2:0] quiet_r, quiet_nxt; // Cycles since last write, saturating

   // Next shadow values; any write restarts the settle count
   always_comb begin
      men_nxt   = (reg_write && reg_addr == `SPWM_A_MASK_EN) ? reg_wdata[5:0] : men_r;
      lvl_nxt   = (reg_write && reg_addr == `SPWM_A_MASK_LVL) ? reg_wdata[5:0] : lvl_r;
      pol_nxt   = (reg_write && reg_addr == `SPWM_A_POL) ? reg_wdata[5:0] : pol_r;
      mode_nxt  = (reg_write && reg_addr == `SPWM_A_MODE) ? reg_wdata[1:0] : mode_r;
      run_nxt   = (reg_write && reg_addr == `SPWM_A_CTRL) ? reg_wdata[0] : run_r;
      quiet_nxt = reg_write ? 3'h0 : ((quiet_r == 3'h4) ? quiet_r : quiet_r + 3'h1);
   end

   // Shadow registers, cleared like the block itself
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         men_r   <= 6'h00;
         lvl_r   <= 6'h00;
         pol_r   <= 6'h00;
         mode_r  <= 2'h0;
         run_r   <= 1'b0;
         quiet_r <= 3'h0;
      end else begin
         men_r   <= men_nxt;
         lvl_r   <= lvl_nxt;
         pol_r   <= pol_nxt;
         mode_r  <= mode_nxt;
         run_r   <= run_nxt;
         quiet_r <= quiet_nxt;
      end
   end

   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);

   // Write then read of the mask enable on the next cycle
   sequence mask_wr; reg_write && reg_addr == `SPWM_A_MASK_EN; endsequence
   sequence mask_rd; reg_read && reg_addr == `SPWM_A_MASK_EN; endsequence

   rdata_idle_a: assert property (!reg_read |=> reg_rdata == 8'h00)
      else $error("read data not zero outside a read");
   unmapped_read_a: assert property (reg_read && reg_addr == 8'h00 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   status_read_a: assert property (reg_read && reg_addr == `SPWM_A_STATUS |=> reg_rdata[5:0] == $past(pwm_out))
      else $error("status does not show the pins");
   mask_readback_a: assert property (mask_wr ##1 mask_rd |=> (reg_rdata & 8'h3f) == ($past(reg_wdata, 2) & 8'h3f))
      else $error("mask enable read back wrong");
   mask_level_a: assert property (quiet_r == 3'h4 |-> ((pwm_out ^ pol_r) & men_r) == (lvl_r & men_r))
      else $error("masked pin not at its level");
   stopped_pins_a: assert property (quiet_r == 3'h4 && !run_r |-> pwm_out == ((men_r & lvl_r) ^ pol_r))
      else $error("idle pins wrong");
   sync_copy_a: assert property (quiet_r == 3'h4 && mode_r == MODE_SYNC && men_r == 6'h00 && pol_r == 6'h00
      |-> pwm_out[1] == pwm_out[0] && pwm_out[3] == pwm_out[2] && pwm_out[5] == pwm_out[4])
      else $error("odd pin differs from even in sync mode");
   no_overlap_a: assert property (quiet_r == 3'h4 && mode_r == MODE_COMPL && men_r == 6'h00 && pol_r == 6'h00
      |-> !(pwm_out[0] && pwm_out[1]))
      else $error("both pins of a pair high");
   reset_pins_a: assert property ($rose(reset_n) |-> pwm_out == 6'h00)
      else $error("pins not low after reset");
endmodule
`default_nettype wire

// ### verif/tb_top.sv
`include "spwm_map.svh"
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import spwm_pkg::*;
   // Port signals and pin tallies
   logic       clock, reset_n, reg_write, reg_read, clr;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
   logic [5:0] pwm_out;
   int         hi_cnt [6];
   int         ex [6];   // Expected high cycles per pin
   int         duty [6]; // Duty model, channels 2..5 stay zero
   int         error_cnt, checked, per, n, dt, men, lvl, pol;
   // Zero after reset, the last entry unmapped
   logic [7:0] rst_list [9] = '{`SPWM_A_PER_HI, `SPWM_A_PER_LO, `SPWM_A_D0_HI, `SPWM_A_D0_LO, `SPWM_A_D1_LO,
                                `SPWM_A_DT_LO, `SPWM_A_MASK_EN, `SPWM_A_POL, 8'h00};

   spwm_top DUT (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
                 .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .pwm_out(pwm_out));
   spwm_stage_mdl u_stage (.clock(clock), .reset_n(reset_n), .clr(clr), .pwm_out(pwm_out), .hi_cnt(hi_cnt));

   always #5 clock = ~clock;

   // Compare and count
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Called just after an edge; the strobe stays up so writes can run back to back
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_read  <= 1'b0;
      reg_write <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clock);
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      reg_write <= 1'b0;
      reg_read  <= 1'b1;
      reg_addr  <= a;
      @(posedge clock);
      reg_read  <= 1'b0;
      #1 rd_val = reg_rdata;
      @(posedge clock);
   endtask

   task automatic rdc(input logic [7:0] a, input int e);
      rd(a);
      chk($sformatf("reg %h", a), 16'(e), {8'h00, rd_val});
   endtask

   // High cycles per pin over one period, independent of phase
   function automatic void model(input int mode, input int gap);
      int raw;
      int g;
      for (int i = 0; i < 6; i++) begin
         g   = (i < 2) ? gap : 0;
         raw = duty[i];
         if (mode == MODE_SYNC && i % 2) raw = duty[i - 1];
         if (mode == MODE_COMPL) raw = (i % 2) ? n - duty[i - 1] - g : duty[i] - g;
         if (men[i]) raw = lvl[i] ? n : 0;
         ex[i] = pol[i] ? n - raw : raw;
      end
   endfunction

   // Settle two periods, then tally exactly one period
   task automatic measure;
      reg_write <= 1'b0;
      repeat (2 * n) @(posedge clock);
      clr <= 1'b1;
      @(posedge clock);
      clr <= 1'b0;
      repeat (n) @(posedge clock);
      #1;
      for (int i = 0; i < 6; i++) chk($sformatf("pin %0d high cycles", i), 16'(ex[i]), 16'(hi_cnt[i]));
      @(posedge clock);
      rd(`SPWM_A_STATUS);
   endtask

   // Program period, duties 0 and 1, dead-time enable, mode, mask and polarity with the counter stopped, then run and measure
   task automatic setup(input int mode, input int en);
      wr(`SPWM_A_CTRL, 8'h00);
      wr(`SPWM_A_DT_EN, en ? 8'h11 : 8'h00);
      wr(`SPWM_A_PER_HI, 8'(per >> 8));
      wr(`SPWM_A_PER_LO, 8'(per));
      wr(`SPWM_A_D0_HI, 8'(duty[0] >> 8));
      wr(`SPWM_A_D0_LO, 8'(duty[0]));
      wr(`SPWM_A_D1_HI, 8'(duty[1] >> 8));
      wr(`SPWM_A_D1_LO, 8'(duty[1]));
      wr(`SPWM_A_MODE, 8'(mode));
      wr(`SPWM_A_MASK_EN, 8'(men));
      wr(`SPWM_A_MASK_LVL, 8'(lvl));
      wr(`SPWM_A_POL, 8'(pol));
      wr(`SPWM_A_CTRL, 8'h01);
      n = per + 1;
      model(mode, (mode == MODE_COMPL && en) ? dt + 257 : 0);
      measure();
   endtask

   task automatic finish_test;
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // Hang guard
   initial begin
      #500000;
      chk("run time limit", 16'h0000, 16'h0001);
      finish_test();
   end

   initial begin
      clock = 1'b0;
      reset_n = 1'b0;
      reg_write = 1'b0;
      reg_read = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      clr = 1'b0;
      error_cnt = 0;
      checked = 0;
      duty = '{default: 0};
      men = 0;
      lvl = 0;
      pol = 0;
      void'($urandom(30));
      repeat (4) @(posedge clock);
      reset_n <= 1'b1;
      foreach (rst_list[i]) rdc(rst_list[i], 0);
      // Locked write must be dropped, unlocked one kept
      wr(`SPWM_A_DT_LO, 8'h5a);
      rdc(`SPWM_A_DT_LO, 0);
      dt = $urandom_range(15, 0);
      wr(`SPWM_A_UNLOCK, `SPWM_KEY_ONE);
      wr(`SPWM_A_UNLOCK, `SPWM_KEY_TWO);
      // Status shows the window open and idle pins; the window still admits the write below
      rdc(`SPWM_A_STATUS, 'h40);
      wr(`SPWM_A_DT_LO, 8'(dt));
      rdc(`SPWM_A_DT_LO, dt);
      // Short period with random duties, boundaries included
      per = $urandom_range(30, 10);
      duty[0] = $urandom_range(per + 1, 0);
      duty[1] = $urandom_range(per + 1, 0);
      setup(MODE_INDEP, 1);
      setup(MODE_SYNC, 0);
      // Long period so the nine-bit gap fits in each half
      per = 1199;
      duty[0] = 600;
      setup(MODE_COMPL, 0);
      setup(MODE_COMPL, 1);
      per = 20;
      duty[0] = 7;
      duty[1] = 13;
      for (int k = 0; k < 4; k++) begin
         men = $urandom_range(63, 0);
         lvl = $urandom_range(63, 0);
         pol = $urandom_range(63, 0);
         setup(k % 2 ? MODE_SYNC : MODE_INDEP, 0);
         wr(`SPWM_A_MASK_EN, 8'(men));
         rdc(`SPWM_A_MASK_EN, men);
      end
      finish_test();
   end
endmodule

bind spwm_top spwm_top_chk u_chk (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
                                  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .pwm_out(pwm_out));
`default_nettype wire

// ### verilog/spwm_map.svh
// Behaviour
// - Period is high byte and low byte
// - Channel 0 duty from low/high bytes
// - Channel 1 duty from low/high bytes
// - Dead time is nine bits, MSB elsewhere
// - Dead time only in complementary, pair enabled
// - Dead time lasts count plus one cycles
// - Dead-time low byte needs timed unlock
// - Synchronous mode: odd outputs copy even ones
// - Mask enable selects software-overridden channels
// - Mask level gives each overridden level
// - Mask bit: 0 generator, 1 level
// - Mask enable resets to zero
// - Polarity inversion acts after masking
// - Polarity bit inverts pin, resets zero
`ifndef SPWM_MAP_SVH
`define SPWM_MAP_SVH

// Register offsets on the byte port
`define SPWM_A_PER_HI    8'hd1
`define SPWM_A_PER_LO    8'hd9
`define SPWM_A_D0_HI     8'hd2
`define SPWM_A_D0_LO     8'hda
`define SPWM_A_D1_HI     8'hd3
`define SPWM_A_D1_LO     8'hdb
`define SPWM_A_D2_HI     8'hd4
`define SPWM_A_D2_LO     8'hdc
`define SPWM_A_D3_HI     8'hd5
`define SPWM_A_D3_LO     8'hdd
`define SPWM_A_D4_HI     8'hd7
`define SPWM_A_D4_LO     8'hde
`define SPWM_A_D5_HI     8'hd8
`define SPWM_A_D5_LO     8'hdf
`define SPWM_A_POL       8'hd6
`define SPWM_A_DT_LO     8'hfa
`define SPWM_A_MASK_EN   8'hfb
`define SPWM_A_MASK_LVL  8'hfc
`define SPWM_A_DT_EN     8'hf9
`define SPWM_A_MODE      8'hf8
`define SPWM_A_CTRL      8'hf7
`define SPWM_A_STATUS    8'hf6
`define SPWM_A_UNLOCK    8'hc7

// Field positions
`define SPWM_DT_MSB_BIT  4
`define SPWM_RUN_BIT     0

// Reset values
`define SPWM_RST_BYTE    8'h00
`define SPWM_RST_WORD    16'h0000
`define SPWM_RST_CH      6'h00

// Unlock sequence and window
`define SPWM_KEY_ONE     8'haa
`define SPWM_KEY_TWO     8'h55
`define SPWM_UNL_WINDOW  3'h4

`endif

// ### verilog/spwm_pkg.sv
`default_nettype none
package spwm_pkg;
   // Unlock sequencer states
   typedef enum logic [2:0] {
      UNL_IDLE  = 3'b001,
      UNL_ARMED = 3'b010,
      UNL_OPEN  = 3'b100
   } spwm_unl_e;
   // Output mode field
   typedef enum logic [1:0] {
      MODE_INDEP = 2'b00,
      MODE_COMPL = 2'b01,
      MODE_SYNC  = 2'b10,
      MODE_RSVD  = 2'b11
   } spwm_mode_e;
   typedef logic [15:0] spwm_word_t;
endpackage
`default_nettype wire

// ### verilog/spwm_top.sv
`include "spwm_map.svh"
`default_nettype none
module spwm_top
   import spwm_pkg::*;
(
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       reset_n,
   // Register port
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_write,
   input  wire logic       reg_read,
   output logic      [7:0] reg_rdata,
   // Power stage pins
   output logic      [5:0] pwm_out
);

   // Channel decode: bit 4 valid, bit 3 high byte, bits 2:0 channel
   function automatic logic [4:0] duty_sel(input logic [7:0] a);
      logic [4:0] s;
      s = 5'h00;
      if (a == `SPWM_A_D0_LO) begin
         s = 5'h10;
      end else if (a == `SPWM_A_D0_HI) begin
         s = 5'h18;
      end else if (a == `SPWM_A_D1_LO) begin
         s = 5'h11;
      end else if (a == `SPWM_A_D1_HI) begin
         s = 5'h19;
      end else if (a == `SPWM_A_D2_LO) begin
         s = 5'h12;
      end else if (a == `SPWM_A_D2_HI) begin
         s = 5'h1a;
      end else if (a == `SPWM_A_D3_LO) begin
         s = 5'h13;
      end else if (a == `SPWM_A_D3_HI) begin
         s = 5'h1b;
      end else if (a == `SPWM_A_D4_LO) begin
         s = 5'h14;
      end else if (a == `SPWM_A_D4_HI) begin
         s = 5'h1c;
      end else if (a == `SPWM_A_D5_LO) begin
         s = 5'h15;
      end else if (a == `SPWM_A_D5_HI) begin
         s = 5'h1d;
      end
      return s;
   endfunction

   // Software-visible state
   spwm_word_t period_value_r, period_value_nxt;          // Period
   spwm_word_t duty_r [6];                                // Channel duties
   spwm_word_t duty_nxt [6];
   logic [7:0] dead_time_count_r, dead_time_count_nxt;    // Dead-time low byte
   logic [7:0] dead_time_enable_r, dead_time_enable_nxt;  // Pair enables, MSB
   logic [1:0] output_mode_select_r, output_mode_select_nxt;
   logic [5:0] output_mask_enable_r, output_mask_enable_nxt;
   logic [5:0] mask_level_r, mask_level_nxt;
   logic [5:0] output_polarity_r, output_polarity_nxt;
   logic       run_r, run_nxt;                            // Generator run
   logic [4:0] wsel;                                      // Decoded duty write

   // Unlock sequencer
   spwm_unl_e  unl_r, unl_nxt;
   logic [2:0] unl_cnt_r, unl_cnt_nxt;                    // Open window left
   logic       dt_wr_ok;                                  // Protected write allowed

   // Generator
   spwm_word_t cnt_r, cnt_nxt;                            // Shared counter
   logic [5:0] gen_raw;                                   // Compare results
   logic [2:0] pair_r, pair_nxt;                          // Last even level
   logic [9:0] gap_r [3];                                 // Dead-time left
   logic [9:0] gap_nxt [3];
   logic [5:0] gen_sig;                                   // After mode logic
   logic [5:0] pin_nxt;                                   // After mask, polarity
   logic [8:0] dt_full;                                   // Nine-bit dead time
   logic [7:0] rdata_nxt;

   assign wsel     = duty_sel(reg_addr);
   assign dt_full  = {dead_time_enable_r[`SPWM_DT_MSB_BIT], dead_time_count_r};
   assign dt_wr_ok = (unl_r == UNL_OPEN);

   // Timed-access unlock: key one, key two, then a short window
   always_comb begin
      unl_nxt     = unl_r;
      unl_cnt_nxt = unl_cnt_r;
      case (unl_r)
         UNL_IDLE: begin
            if (reg_write && reg_addr == `SPWM_A_UNLOCK && reg_wdata == `SPWM_KEY_ONE) begin
               unl_nxt = UNL_ARMED;
            end
         end
         UNL_ARMED: begin
            // Any other write breaks the sequence
            if (reg_write) begin
               if (reg_addr == `SPWM_A_UNLOCK && reg_wdata == `SPWM_KEY_TWO) begin
                  unl_nxt     = UNL_OPEN;
                  unl_cnt_nxt = `SPWM_UNL_WINDOW;
               end else begin
                  unl_nxt = UNL_IDLE;
               end
            end
         end
         UNL_OPEN: begin
            // One protected write per unlock, or the window lapses
            if ((reg_write && reg_addr == `SPWM_A_DT_LO) || unl_cnt_r == 3'h1) begin
               unl_nxt = UNL_IDLE;
            end
            unl_cnt_nxt = unl_cnt_r - 3'h1;
         end
         default: begin
            unl_nxt = UNL_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         unl_r     <= UNL_IDLE;
         unl_cnt_r <= 3'h0;
      end else begin
         unl_r     <= unl_nxt;
         unl_cnt_r <= unl_cnt_nxt;
      end
   end

   // Register writes
   always_comb begin
      period_value_nxt       = period_value_r;
      dead_time_count_nxt    = dead_time_count_r;
      dead_time_enable_nxt   = dead_time_enable_r;
      output_mode_select_nxt = output_mode_select_r;
      output_mask_enable_nxt = output_mask_enable_r;
      mask_level_nxt         = mask_level_r;
      output_polarity_nxt    = output_polarity_r;
      run_nxt                = run_r;
      for (int i = 0; i < 6; i++) begin
         duty_nxt[i] = duty_r[i];
      end
      if (reg_write) begin
         if (reg_addr == `SPWM_A_PER_HI) begin
            period_value_nxt[15:8] = reg_wdata;
         end else if (reg_addr == `SPWM_A_PER_LO) begin
            period_value_nxt[7:0] = reg_wdata;
         end else if (wsel[4]) begin
            // Byte lands in one half of the channel duty
            if (wsel[3]) begin
               duty_nxt[wsel[2:0]][15:8] = reg_wdata;
            end else begin
               duty_nxt[wsel[2:0]][7:0] = reg_wdata;
            end
         end else if (reg_addr == `SPWM_A_DT_LO) begin
            // Ignored silently when not unlocked
            if (dt_wr_ok) begin
               dead_time_count_nxt = reg_wdata;
            end
         end else if (reg_addr == `SPWM_A_DT_EN) begin
            dead_time_enable_nxt = reg_wdata & 8'h17;
         end else if (reg_addr == `SPWM_A_MODE) begin
            output_mode_select_nxt = reg_wdata[1:0];
         end else if (reg_addr == `SPWM_A_MASK_EN) begin
            output_mask_enable_nxt = reg_wdata[5:0];
         end else if (reg_addr == `SPWM_A_MASK_LVL) begin
            mask_level_nxt = reg_wdata[5:0];
         end else if (reg_addr == `SPWM_A_POL) begin
            output_polarity_nxt = reg_wdata[5:0];
         end else if (reg_addr == `SPWM_A_CTRL) begin
            run_nxt = reg_wdata[`SPWM_RUN_BIT];
         end
      end
   end

   // Software state; mask and polarity come up clear
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         period_value_r       <= `SPWM_RST_WORD;
         dead_time_count_r    <= `SPWM_RST_BYTE;
         dead_time_enable_r   <= `SPWM_RST_BYTE;
         output_mode_select_r <= 2'h0;
         output_mask_enable_r <= `SPWM_RST_CH;
         mask_level_r         <= `SPWM_RST_CH;
         output_polarity_r    <= `SPWM_RST_CH;
         run_r                <= 1'b0;
         for (int i = 0; i < 6; i++) begin
            duty_r[i] <= `SPWM_RST_WORD;
         end
      end else begin
         period_value_r       <= period_value_nxt;
         dead_time_count_r    <= dead_time_count_nxt;
         dead_time_enable_r   <= dead_time_enable_nxt;
         output_mode_select_r <= output_mode_select_nxt;
         output_mask_enable_r <= output_mask_enable_nxt;
         mask_level_r         <= mask_level_nxt;
         output_polarity_r    <= output_polarity_nxt;
         run_r                <= run_nxt;
         for (int i = 0; i < 6; i++) begin
            duty_r[i] <= duty_nxt[i];
         end
      end
   end

   // Shared up counter, wraps after reaching the period
   always_comb begin
      if (!run_r || cnt_r >= period_value_r) begin
         cnt_nxt = `SPWM_RST_WORD;
      end else begin
         cnt_nxt = cnt_r + 16'h0001;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cnt_r <= `SPWM_RST_WORD;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   // Edge-aligned compare; a stopped generator drives low
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         gen_raw[i] = run_r && (cnt_r < duty_r[i]);
      end
   end

   // Dead-time gap per pair; reload on each even-side transition.
   // Changing the count mid-run only takes effect at the next edge.
   always_comb begin
      for (int p = 0; p < 3; p++) begin
         pair_nxt[p] = gen_raw[2*p];
         gap_nxt[p]  = gap_r[p];
         if (output_mode_select_r == MODE_COMPL && dead_time_enable_r[p]) begin
            if (gen_raw[2*p] != pair_r[p]) begin
               gap_nxt[p] = {1'b0, dt_full} + 10'h001;
            end else if (gap_r[p] != 10'h000) begin
               gap_nxt[p] = gap_r[p] - 10'h001;
            end
         end else begin
            gap_nxt[p] = 10'h000;
         end
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         pair_r <= 3'h0;
         for (int p = 0; p < 3; p++) begin
            gap_r[p] <= 10'h000;
         end
      end else begin
         pair_r <= pair_nxt;
         for (int p = 0; p < 3; p++) begin
            gap_r[p] <= gap_nxt[p];
         end
      end
   end

   // Mode logic, then mask, then polarity toward the pins
   always_comb begin
      gen_sig = gen_raw;
      for (int p = 0; p < 3; p++) begin
         if (output_mode_select_r == MODE_SYNC) begin
            gen_sig[2*p+1] = gen_raw[2*p];
         end else if (output_mode_select_r == MODE_COMPL) begin
            // Pair delayed one cycle so the gap counter lines up with it
            gen_sig[2*p]   = pair_r[p] && (gap_r[p] == 10'h000);
            gen_sig[2*p+1] = !pair_r[p] && run_r && (gap_r[p] == 10'h000);
         end
      end
      for (int i = 0; i < 6; i++) begin
         pin_nxt[i] = output_mask_enable_r[i] ? mask_level_r[i] : gen_sig[i];
         pin_nxt[i] = pin_nxt[i] ^ output_polarity_r[i];
      end
   end

   // Read mux; unmapped addresses read zero
   always_comb begin
      rdata_nxt = 8'h00;
      if (reg_read) begin
         if (reg_addr == `SPWM_A_PER_HI) begin
            rdata_nxt = period_value_r[15:8];
         end else if (reg_addr == `SPWM_A_PER_LO) begin
            rdata_nxt = period_value_r[7:0];
         end else if (wsel[4]) begin
            rdata_nxt = wsel[3] ? duty_r[wsel[2:0]][15:8] : duty_r[wsel[2:0]][7:0];
         end else if (reg_addr == `SPWM_A_DT_LO) begin
            rdata_nxt = dead_time_count_r;
         end else if (reg_addr == `SPWM_A_DT_EN) begin
            rdata_nxt = dead_time_enable_r;
         end else if (reg_addr == `SPWM_A_MODE) begin
            rdata_nxt = {6'h00, output_mode_select_r};
         end else if (reg_addr == `SPWM_A_MASK_EN) begin
            rdata_nxt = {2'h0, output_mask_enable_r};
         end else if (reg_addr == `SPWM_A_MASK_LVL) begin
            rdata_nxt = {2'h0, mask_level_r};
         end else if (reg_addr == `SPWM_A_POL) begin
            rdata_nxt = {2'h0, output_polarity_r};
         end else if (reg_addr == `SPWM_A_CTRL) begin
            rdata_nxt = {7'h00, run_r};
         end else if (reg_addr == `SPWM_A_STATUS) begin
            // Live pin levels plus unlock-open flag
            rdata_nxt = {1'b0, dt_wr_ok, pwm_out};
         end
      end
   end

   // Pins and read data from flip-flops
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         pwm_out   <= 6'h00;
         reg_rdata <= 8'h00;
      end else begin
         pwm_out   <= pin_nxt;
         reg_rdata <= rdata_nxt;
      end
   end

endmodule
`default_nettype wire
